// ===== hw/dlbg_regs.svh
// constants for the debug lock and boot guard
// assumes: included by bare name from the guard module
`ifndef DLBG_REGS_SVH
`define DLBG_REGS_SVH
`define DLBG_BMODE_PINS    2'h0
`define DLBG_BMODE_FLASH   2'h1
`define DLBG_BMODE_SECURE  2'h2
`define DLBG_SAMPLE_CYCLES 4'h4
`define DLBG_SYNC_W        5
`define DLBG_SYNC_TCK      0
`define DLBG_SYNC_TDI      1
`define DLBG_SYNC_KEY      2
`define DLBG_SYNC_BOOT_LO  3
`define DLBG_SYNC_BOOT_HI  4
`endif

// ===== hw/dlbg_pkg.sv
// types shared by the debug lock and boot guard
// assumes: nothing beyond the constants header
package dlbg_pkg;
  typedef enum logic [1:0] {
    G_RESET  = 2'b00,
    G_SAMPLE = 2'b01,
    G_RUN    = 2'b10
  } guard_e;

  typedef enum logic [2:0] {
    B_WAIT   = 3'b000,
    B_CHECK  = 3'b001,
    B_FLASH  = 3'b010,
    B_LOADER = 3'b011,
    B_HALT   = 3'b100
  } boot_e;

  typedef struct packed {
    logic       lock_en;
    logic       zero_pin;
    logic [1:0] boot_mode;
  } otp_s;

  typedef struct packed {
    logic       flash_go;
    logic       loader_go;
    logic [1:0] loader_sel;
    logic       check_req;
    logic       halt;
  } boot_s;
endpackage

// ===== hw/debug_lock_boot_guard.sv
// debug port lock and zero-pin boot guard, system clock domain
// assumes: otp and boot rom signals are on I_CLOCK; jtag and boot pins are asynchronous
//
// Notes on behaviour
// - debug lock enabled in otp blocks all jtag access to the device
// - while locked, a matching presented password lifts the lock; nothing else does
// - an all-zero stored password makes the lock permanent
// - zero-pin with a flash mode jumps to flash, ignoring boot pins and loaders
// - secure flash mode with zero-pin checks the flash image before handing over; without zero-pin it goes to a loader unchecked
// - external loaders never run when zero-pin flash boot is set
`timescale 1ns/100ps
`include "dlbg_regs.svh"

module debug_lock_boot_guard #(
  parameter int KEY_W = 64
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RESETN,
  input  wire dlbg_pkg::otp_s    i_otp_cfg,
  input  wire logic [KEY_W-1:0]  i_otp_key,
  input  wire logic              I_JTAG_TCK,
  input  wire logic              I_JTAG_TDI,
  input  wire logic              I_KEY_ENTER,
  input  wire logic [1:0]        I_BOOT_PINS,
  input  wire logic              i_rom_done,
  input  wire logic              i_check_done,
  input  wire logic              i_check_pass,
  output logic                   o_eval_done,
  output logic                   o_jtag_enable,
  output logic                   o_debug_port_lock,
  output logic                   o_lock_permanent,
  output dlbg_pkg::boot_s        o_boot
);

  // input synchronisers; stage one feeds stage two only
  logic [`DLBG_SYNC_W-1:0] s1_q;
  logic [`DLBG_SYNC_W-1:0] s2_q;
  logic                    tck_prev_q;
  logic                    key_prev_q;
  logic                    tck_rise;
  logic                    key_fall;
  logic                    key_en;
  logic                    tdi;
  logic [1:0]              boot_pins;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      s1_q       <= '0;
      s2_q       <= '0;
      tck_prev_q <= 1'b0;
      key_prev_q <= 1'b0;
    end else begin
      s1_q       <= {I_BOOT_PINS, I_KEY_ENTER, I_JTAG_TDI, I_JTAG_TCK};
      s2_q       <= s1_q;
      tck_prev_q <= s2_q[`DLBG_SYNC_TCK];
      key_prev_q <= s2_q[`DLBG_SYNC_KEY];
    end
  end

  always_comb begin
    tck_rise  = s2_q[`DLBG_SYNC_TCK] & ~tck_prev_q;
    key_en    = s2_q[`DLBG_SYNC_KEY];
    key_fall  = ~key_en & key_prev_q;
    tdi       = s2_q[`DLBG_SYNC_TDI];
    boot_pins = s2_q[`DLBG_SYNC_BOOT_HI:`DLBG_SYNC_BOOT_LO];
  end

  // evaluation of otp settings and debug lock
  dlbg_pkg::guard_e   guard_q, guard_d;
  logic [3:0]         cnt_q, cnt_d;
  dlbg_pkg::otp_s     otp_q, otp_d;
  logic [KEY_W-1:0]   stored_q, stored_d;
  logic [KEY_W-1:0]   shift_q, shift_d;
  logic               locked_q, locked_d;
  logic               perm;
  logic               key_match;

  always_comb begin
    guard_d   = guard_q;
    cnt_d     = cnt_q;
    otp_d     = otp_q;
    stored_d  = stored_q;
    shift_d   = shift_q;
    locked_d  = locked_q;
    perm      = otp_q.lock_en & (stored_q == '0);
    // a submit that lands before evaluation finishes is refused
    key_match = key_fall & locked_q & ~perm & (shift_q == stored_q)
                & (guard_q == dlbg_pkg::G_RUN);
    case (guard_q)
      dlbg_pkg::G_RESET: begin
        guard_d = dlbg_pkg::G_SAMPLE;
        cnt_d   = '0;
      end
      dlbg_pkg::G_SAMPLE: begin
        // otp read path may settle late after reset, so sample repeatedly
        otp_d    = i_otp_cfg;
        stored_d = i_otp_key;
        cnt_d    = cnt_q + 4'h1;
        if (cnt_q == `DLBG_SAMPLE_CYCLES - 4'h1) begin
          guard_d  = dlbg_pkg::G_RUN;
          locked_d = i_otp_cfg.lock_en;
        end
      end
      dlbg_pkg::G_RUN: begin
        if (key_en && tck_rise) begin
          shift_d = {shift_q[KEY_W-2:0], tdi};
        end
        if (key_match) begin
          locked_d = 1'b0;
        end
        if (key_fall) begin
          shift_d = '0;
        end
      end
      default: guard_d = dlbg_pkg::G_RESET;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      guard_q  <= dlbg_pkg::G_RESET;
      cnt_q    <= '0;
      otp_q    <= '0;
      stored_q <= '0;
      shift_q  <= '0;
      locked_q <= 1'b1;
    end else begin
      guard_q  <= guard_d;
      cnt_q    <= cnt_d;
      otp_q    <= otp_d;
      stored_q <= stored_d;
      shift_q  <= shift_d;
      locked_q <= locked_d;
    end
  end

  // boot path selection
  dlbg_pkg::boot_e boot_q, boot_d;
  dlbg_pkg::boot_s out_q, out_d;
  logic            zp_flash;
  logic            secure;

  always_comb begin
    zp_flash = otp_q.zero_pin & (otp_q.boot_mode != `DLBG_BMODE_PINS);
    secure   = otp_q.boot_mode == `DLBG_BMODE_SECURE;
    boot_d   = boot_q;
    out_d    = out_q;
    case (boot_q)
      dlbg_pkg::B_WAIT: begin
        if (guard_q == dlbg_pkg::G_RUN && i_rom_done) begin
          if (zp_flash) begin
            boot_d = secure ? dlbg_pkg::B_CHECK : dlbg_pkg::B_FLASH;
          end else begin
            // loaders take code unauthenticated; only reachable without zero-pin flash boot
            boot_d           = dlbg_pkg::B_LOADER;
            out_d.loader_sel = boot_pins;
          end
        end
      end
      dlbg_pkg::B_CHECK: begin
        if (i_check_done) begin
          boot_d = i_check_pass ? dlbg_pkg::B_FLASH : dlbg_pkg::B_HALT;
        end
      end
      dlbg_pkg::B_FLASH,
      dlbg_pkg::B_LOADER,
      dlbg_pkg::B_HALT: boot_d = boot_q;
      default: boot_d = dlbg_pkg::B_WAIT;
    endcase
    out_d.flash_go  = boot_d == dlbg_pkg::B_FLASH;
    out_d.loader_go = boot_d == dlbg_pkg::B_LOADER;
    out_d.check_req = boot_d == dlbg_pkg::B_CHECK;
    out_d.halt      = boot_d == dlbg_pkg::B_HALT;
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      boot_q <= dlbg_pkg::B_WAIT;
      out_q  <= '0;
    end else begin
      boot_q <= boot_d;
      out_q  <= out_d;
    end
  end

  // outputs, all from flip-flops
  logic eval_q;
  logic jtag_q;
  logic perm_q;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      eval_q <= 1'b0;
      jtag_q <= 1'b0;
      perm_q <= 1'b0;
    end else begin
      eval_q <= guard_d == dlbg_pkg::G_RUN;
      jtag_q <= (guard_d == dlbg_pkg::G_RUN) & ~locked_d;
      perm_q <= (guard_d == dlbg_pkg::G_RUN) & otp_d.lock_en & (stored_d == '0);
    end
  end

  assign o_eval_done       = eval_q;
  assign o_jtag_enable     = jtag_q;
  assign o_debug_port_lock = locked_q;
  assign o_lock_permanent  = perm_q;
  assign o_boot            = out_q;

  // checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);

  sequence s_key_ok;
    key_match;
  endsequence

  sequence s_unlocked_open;
    !locked_q ##0 o_jtag_enable;
  endsequence

  property p_blocked_until_eval;
    !o_eval_done |-> !o_jtag_enable;
  endproperty
  a_blocked_until_eval: assert property (p_blocked_until_eval)
    else $error("jtag enabled before evaluation finished");

  property p_lock_refuses;
    locked_q |-> !o_jtag_enable;
  endproperty
  a_lock_refuses: assert property (p_lock_refuses)
    else $error("jtag enabled while locked");

  property p_unlock_on_match;
    s_key_ok |=> s_unlocked_open;
  endproperty
  a_unlock_on_match: assert property (p_unlock_on_match)
    else $error("matching password did not open jtag");

  property p_unlock_only_match;
    $fell(locked_q) && $past(guard_q == dlbg_pkg::G_RUN) |-> $past(key_match);
  endproperty
  a_unlock_only_match: assert property (p_unlock_only_match)
    else $error("lock lifted without a password match");

  property p_permanent;
    o_lock_permanent |-> locked_q ##1 locked_q;
  endproperty
  a_permanent: assert property (p_permanent)
    else $error("permanent lock was lifted");

  property p_zero_pin_direct;
    boot_q == dlbg_pkg::B_WAIT && guard_q == dlbg_pkg::G_RUN && i_rom_done
      && zp_flash && !secure |=> ##1 o_boot.flash_go && !o_boot.loader_go;
  endproperty
  a_zero_pin_direct: assert property (p_zero_pin_direct)
    else $error("zero-pin flash boot did not go straight to flash");

  property p_secure_checked;
    $rose(o_boot.flash_go) && secure |-> $past(o_boot.check_req)
      && $past(i_check_done) && $past(i_check_pass);
  endproperty
  a_secure_checked: assert property (p_secure_checked)
    else $error("secure flash entered without a passing image check");

  property p_no_loader;
    o_boot.loader_go |-> !zp_flash;
  endproperty
  a_no_loader: assert property (p_no_loader)
    else $error("external loader started under zero-pin flash boot");

endmodule

// ===== testbench/jtag_host_model.sv
// behavioural debugger that shifts a password into the guard over its jtag pins
// assumes: the guard samples these pins with its own clock; tck idles low between frames
`timescale 1ns/100ps

module jtag_host_model #(
  parameter int KEY_W = 8
) (
  output logic o_tck,
  output logic o_tdi,
  output logic o_key_enter
);
  initial begin
    o_tck       = 1'h0;
    o_tdi       = 1'h0;
    o_key_enter = 1'h0;
  end

  // msb first, 80 ns tck only inside the frame
  task automatic send_key(input logic [KEY_W-1:0] key);
    o_key_enter = 1'h1;
    for (int i = KEY_W - 1; i >= 0; i--) begin
      o_tdi = key[i];
      #40;
      o_tck = 1'h1;
      #40;
      o_tck = 1'h0;
    end
    #40;
    o_key_enter = 1'h0;
    // released data line must not keep the last bit
    o_tdi       = ~o_tdi;
  endtask
endmodule

// ===== testbench/debug_lock_boot_guard_tb.sv
// self-checking bench for the debug lock and boot guard
// assumes: 100 MHz clock; each case resets the guard since outcomes stick until reset
`timescale 1ns/100ps

module debug_lock_boot_guard_tb;
  localparam int KW = 8;
  logic            clk      = 1'h0;
  logic            rst_n    = 1'h0;
  dlbg_pkg::otp_s  cfg      = '0;
  logic [KW-1:0]   key      = '0;
  logic [1:0]      pins     = 2'h0;
  logic            rom_done = 1'h0;
  logic            chk_done = 1'h0;
  logic            chk_pass = 1'h0;
  logic            tck;
  logic            tdi;
  logic            kent;
  logic            eval_done;
  logic            jtag_en;
  logic            perm;
  logic            lock;
  dlbg_pkg::boot_s boot;
  int              n_mismatch = 0;
  int              tests_run  = 0;

  always #5 clk = ~clk;

  jtag_host_model #(.KEY_W(KW)) u_host (.o_tck(tck), .o_tdi(tdi), .o_key_enter(kent));

  debug_lock_boot_guard #(.KEY_W(KW)) u_dut (
    .I_CLOCK(clk), .I_RESETN(rst_n), .i_otp_cfg(cfg), .i_otp_key(key),
    .I_JTAG_TCK(tck), .I_JTAG_TDI(tdi), .I_KEY_ENTER(kent), .I_BOOT_PINS(pins),
    .i_rom_done(rom_done), .i_check_done(chk_done), .i_check_pass(chk_pass),
    .o_eval_done(eval_done), .o_jtag_enable(jtag_en), .o_debug_port_lock(lock),
    .o_lock_permanent(perm), .o_boot(boot));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // c is {lock_en, zero_pin, boot_mode}; ps is the image check verdict
  task automatic run_case(input logic [3:0] c, input logic [KW-1:0] k,
                          input logic [1:0] p, input logic ps);
    logic en;
    logic pm;
    logic fl;
    logic sec;
    logic [7:0] exp_boot;
    en  = c[3];
    pm  = en && (k == '0);
    fl  = c[2] && (c[1:0] != 2'h0);
    sec = fl && (c[1:0] == 2'h2);
    // check request drops once the verdict moves the boot path on
    exp_boot = {2'h0, fl && (!sec || ps), !fl, fl ? 2'h0 : p, 1'h0, sec && !ps};
    @(posedge clk);
    rst_n    <= 1'h0;
    cfg      <= c;
    key      <= k;
    pins     <= p;
    rom_done <= 1'h0;
    chk_pass <= ps;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("early_jtag", 8'h00, {6'h0, eval_done, jtag_en});
    repeat (5) @(posedge clk);
    #1;
    chk("eval_done", 8'h01, {7'h0, eval_done});
    chk("jtag_locked", {7'h0, !en}, {7'h0, jtag_en});
    chk("lock", {7'h0, en}, {7'h0, lock});
    chk("permanent", {7'h0, pm}, {7'h0, perm});
    u_host.send_key(k ^ 8'h01);
    repeat (10) @(posedge clk);
    #1;
    chk("wrong_key", {7'h0, !en}, {7'h0, jtag_en});
    u_host.send_key(k);
    repeat (10) @(posedge clk);
    #1;
    chk("right_key", {7'h0, !pm}, {7'h0, jtag_en});
    chk("lock_after_key", {7'h0, pm}, {7'h0, lock});
    @(posedge clk);
    rom_done <= 1'h1;
    repeat (4) @(posedge clk);
    if (sec) begin
      chk_done <= 1'h1;
      #1;
      chk("check_req", 8'h01, {7'h0, boot.check_req});
      @(posedge clk);
      chk_done <= 1'h0;
    end
    repeat (4) @(posedge clk);
    #1;
    chk("boot", exp_boot, {2'h0, boot});
  endtask

  initial begin
    run_case(4'hd, 8'ha5, 2'h2, 1'h1);
    run_case(4'he, 8'h00, 2'h1, 1'h1);
    run_case(4'h1, 8'h5a, 2'h3, 1'h1);
    run_case(4'he, 8'h3c, 2'h0, 1'h0);
    run_case(4'h4, 8'h77, 2'h1, 1'h0);
    run_case(4'hf, 8'h81, 2'h2, 1'h1);
    summarize();
  end

  // six cases take about 11 us; a hang is cut well past that
  initial begin
    #300000;
    n_mismatch++;
    summarize();
  end
endmodule
